/* integrator_trim_consts.vh */
// Purpose: shared constants of the process value integrator and trim block
// Assumes: 100 MHz aclk, AXI4-Lite register window with 32-bit data
// Notes: every register is one aligned word, 16-bit data sits in the low bits
`ifndef INTEGRATOR_TRIM_CONSTS_VH
`define INTEGRATOR_TRIM_CONSTS_VH

// register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_IN_MIN 8'h04
`define ADDR_IN_GAIN 8'h08
`define ADDR_IN_ZERO 8'h0c
`define ADDR_PV 8'h10
`define ADDR_TOTAL_LO 8'h14
`define ADDR_TOTAL_HI 8'h18
`define ADDR_OUT_SET 8'h1c
`define ADDR_OUT_MIN 8'h20
`define ADDR_OUT_GAIN 8'h24
`define ADDR_OUT_ZERO 8'h28
`define ADDR_STATUS 8'h2c

// control fields
`define CTRL_RUN_BIT 0
`define CTRL_MINUTE_BIT 1
`define CTRL_CLEAR_BIT 2

// reset values
`define RST_RANGE_MIN 16'h0000
`define RST_GAIN 16'h2710
`define RST_ZERO 16'h0000

// gain weight 0.0001 per count: 10000 counts is unity, 5000 is one half
`define GAIN_ONE 36'sd10000
`define GAIN_HALF 36'sd5000

// one integration step is one thousandth of the time base unit
`define STEPS_PER_UNIT 18'sd1000

// step widths in ms and the clock rate in kHz
`define STEP_HOUR_MS 3600
`define STEP_MINUTE_MS 60
`define CLK_KHZ 100000

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* value_trim.v */
// Purpose: zero/span correction of one 16-bit value
// Assumes: settings are steady while a value is in flight
// Notes: two cycles from din_valid to dout_valid, result clipped to 16 bits
`timescale 1ns/100ps
`include "integrator_trim_consts.vh"

module value_trim (
	input wire aclk,
	input wire aresetn,
	input wire [15:0] din,
	input wire din_valid,
	input wire [15:0] range_min,
	input wire [15:0] span_gain,
	input wire [15:0] zero_adj,
	output reg [15:0] dout,
	output reg dout_valid
);
	reg signed [33:0] prod_q;
	reg signed [17:0] base_q;
	reg v1_q;
	wire signed [16:0] diff;
	wire signed [35:0] prod_ext;
	wire signed [35:0] biased;
	wire signed [35:0] scaled;
	wire signed [35:0] summed;

	// gain is unsigned, so it enters the product with a zero sign bit
	assign diff = {din[15], din} - {range_min[15], range_min};
	assign prod_ext = {{2{prod_q[33]}}, prod_q};
	// half a count away from zero, then truncate: round to nearest
	assign biased = prod_ext + (prod_q[33] ? -`GAIN_HALF : `GAIN_HALF);
	assign scaled = biased / `GAIN_ONE;
	assign summed = scaled + {{18{base_q[17]}}, base_q};

	always @(posedge aclk) begin
		if (!aresetn) begin
			prod_q <= 34'sd0;
			base_q <= 18'sd0;
			v1_q <= 1'b0;
			dout <= 16'h0000;
			dout_valid <= 1'b0;
		end else begin
			v1_q <= din_valid;
			dout_valid <= v1_q;
			if (din_valid) begin
				prod_q <= diff * $signed({1'b0, span_gain});
				base_q <= {{2{range_min[15]}}, range_min} + {{2{zero_adj[15]}}, zero_adj};
			end
			// clipping keeps a large gain from wrapping the sign
			if (v1_q) begin
				if (summed > 36'sd32767)
					dout <= 16'h7fff;
				else if (summed < -36'sd32768)
					dout <= 16'h8000;
				else
					dout <= summed[15:0];
			end
		end
	end
endmodule

/* process_value_integrator_and_trim.v */
// Purpose: trimmed process value, its time integral, and trimmed output value
// Assumes: raw_value and its strobe come from logic on aclk
// Notes: registers over AXI4-Lite, one write and one read under way at a time
`timescale 1ns/100ps
`include "integrator_trim_consts.vh"

// Function
// - hour base adds one step every 3.6 s
// - minute base adds one step every 60 ms
// - constant value for one unit adds that value
// - total is 32 bits in two 16-bit words
// - accumulate signed, negative values decrease total
// - overflow wraps, neither saturated nor flagged
// - start bit and clear control for the total
// - (raw - min) * gain + min + zero
// - gain unsigned, 0.0001 per count
// - output values get the same correction
module process_value_integrator_and_trim #(
	parameter HOUR_STEP_CYCLES = `STEP_HOUR_MS * `CLK_KHZ,
	parameter MINUTE_STEP_CYCLES = `STEP_MINUTE_MS * `CLK_KHZ
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] raw_value,
	input wire raw_valid,
	output wire [15:0] out_value,
	output wire out_valid
);
	localparam [31:0] HOUR_LAST = HOUR_STEP_CYCLES - 1;
	localparam [31:0] MINUTE_LAST = MINUTE_STEP_CYCLES - 1;

	// write channel holding registers
	reg aw_hold_q;
	reg [7:0] aw_addr_q;
	reg w_hold_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;

	// software settings
	reg run_q;
	reg minute_q;
	reg clear_q;
	reg [15:0] in_min_q;
	reg [15:0] in_gain_q;
	reg [15:0] in_zero_q;
	reg [15:0] out_set_q;
	reg out_start_q;
	reg [15:0] out_min_q;
	reg [15:0] out_gain_q;
	reg [15:0] out_zero_q;

	// integrator state
	reg [31:0] tick_cnt_q;
	reg [9:0] rem_q;
	reg [31:0] total_q;
	reg [15:0] total_hi_snap_q;
	reg steps_seen_q;

	// next-state values of the integrator
	reg [31:0] tick_cnt_d;
	reg [9:0] rem_d;
	reg [31:0] total_d;
	reg steps_seen_d;

	// next-state values of the read channel
	reg rvalid_d;
	reg [31:0] rdata_d;
	reg [1:0] rresp_d;
	reg [15:0] total_hi_snap_d;

	wire [15:0] pv;
	wire pv_valid;
	reg [15:0] pv_q;

	wire do_write;
	wire do_read;
	wire [31:0] tick_last;
	wire tick;
	wire signed [17:0] step_sum;
	wire signed [17:0] step_q0;
	wire signed [17:0] step_r0;
	wire signed [17:0] step_quot;
	wire [9:0] step_rem;
	reg [31:0] rd_word;
	reg rd_hit;
	reg wr_hit;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
			merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
		end
	endfunction

	// handshake outputs: a channel is free while nothing is held for it
	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready = !w_hold_q;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && !s_axi_rvalid;

	always @* begin
		case (aw_addr_q)
			`ADDR_CTRL,
			`ADDR_IN_MIN,
			`ADDR_IN_GAIN,
			`ADDR_IN_ZERO,
			`ADDR_OUT_SET,
			`ADDR_OUT_MIN,
			`ADDR_OUT_GAIN,
			`ADDR_OUT_ZERO: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_hold_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_hold_q) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_hold_q) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			run_q <= 1'b0;
			minute_q <= 1'b0;
			clear_q <= 1'b0;
			in_min_q <= `RST_RANGE_MIN;
			in_gain_q <= `RST_GAIN;
			in_zero_q <= `RST_ZERO;
			out_set_q <= 16'h0000;
			out_start_q <= 1'b0;
			out_min_q <= `RST_RANGE_MIN;
			out_gain_q <= `RST_GAIN;
			out_zero_q <= `RST_ZERO;
		end else begin
			clear_q <= 1'b0;
			out_start_q <= 1'b0;
			if (do_write) begin
				case (aw_addr_q)
					`ADDR_CTRL: begin
						if (w_strb_q[0]) begin
							run_q <= w_data_q[`CTRL_RUN_BIT];
							minute_q <= w_data_q[`CTRL_MINUTE_BIT];
							clear_q <= w_data_q[`CTRL_CLEAR_BIT];
						end
					end
					`ADDR_IN_MIN: in_min_q <= merge16(in_min_q, w_data_q, w_strb_q);
					`ADDR_IN_GAIN: in_gain_q <= merge16(in_gain_q, w_data_q, w_strb_q);
					`ADDR_IN_ZERO: in_zero_q <= merge16(in_zero_q, w_data_q, w_strb_q);
					`ADDR_OUT_SET: begin
						out_set_q <= merge16(out_set_q, w_data_q, w_strb_q);
						out_start_q <= 1'b1;
					end
					`ADDR_OUT_MIN: out_min_q <= merge16(out_min_q, w_data_q, w_strb_q);
					`ADDR_OUT_GAIN: out_gain_q <= merge16(out_gain_q, w_data_q, w_strb_q);
					`ADDR_OUT_ZERO: out_zero_q <= merge16(out_zero_q, w_data_q, w_strb_q);
					default: begin
					end
				endcase
			end
		end
	end

	// input channel correction
	value_trim in_trim (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(raw_value),
		.din_valid(raw_valid),
		.range_min(in_min_q),
		.span_gain(in_gain_q),
		.zero_adj(in_zero_q),
		.dout(pv),
		.dout_valid(pv_valid)
	);

	// output channel correction, started by each write of the set value
	value_trim out_trim (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(out_set_q),
		.din_valid(out_start_q),
		.range_min(out_min_q),
		.span_gain(out_gain_q),
		.zero_adj(out_zero_q),
		.dout(out_value),
		.dout_valid(out_valid)
	);

	always @(posedge aclk) begin
		if (!aresetn)
			pv_q <= 16'h0000;
		else if (pv_valid)
			pv_q <= pv;
	end

	// step timer: a base change mid-step takes effect on the running count
	assign tick_last = minute_q ? MINUTE_LAST : HOUR_LAST;
	assign tick = run_q && (tick_cnt_q >= tick_last);

	// each step adds pv/1000; the remainder carries so long runs stay exact
	assign step_sum = $signed({8'h00, rem_q}) + $signed({{2{pv_q[15]}}, pv_q});
	assign step_q0 = step_sum / `STEPS_PER_UNIT;
	assign step_r0 = step_sum - step_q0 * `STEPS_PER_UNIT;
	assign step_quot = step_r0[17] ? step_q0 - 18'sd1 : step_q0;
	assign step_rem = step_r0[17] ? step_r0[9:0] + 10'd1000 : step_r0[9:0];

	// a software clear outranks a step landing in the same cycle
	always @* begin
		tick_cnt_d = tick_cnt_q + 32'h00000001;
		rem_d = rem_q;
		total_d = total_q;
		steps_seen_d = steps_seen_q;
		if (clear_q) begin
			tick_cnt_d = 32'h00000000;
			rem_d = 10'd0;
			total_d = 32'h00000000;
			steps_seen_d = 1'b0;
		end else if (!run_q) begin
			tick_cnt_d = 32'h00000000;
		end else if (tick) begin
			tick_cnt_d = 32'h00000000;
			rem_d = step_rem;
			// plain two's complement wrap past the 32-bit range
			total_d = total_q + {{14{step_quot[17]}}, step_quot};
			steps_seen_d = 1'b1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q <= 32'h00000000;
			rem_q <= 10'd0;
			total_q <= 32'h00000000;
			steps_seen_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			rem_q <= rem_d;
			total_q <= total_d;
			steps_seen_q <= steps_seen_d;
		end
	end

	always @* begin
		rd_hit = 1'b1;
		rd_word = 32'h00000000;
		case ({s_axi_araddr[7:2], 2'b00})
			`ADDR_CTRL: rd_word = {29'h00000000, 1'b0, minute_q, run_q};
			`ADDR_IN_MIN: rd_word = {16'h0000, in_min_q};
			`ADDR_IN_GAIN: rd_word = {16'h0000, in_gain_q};
			`ADDR_IN_ZERO: rd_word = {16'h0000, in_zero_q};
			`ADDR_PV: rd_word = {16'h0000, pv_q};
			`ADDR_TOTAL_LO: rd_word = {16'h0000, total_q[15:0]};
			`ADDR_TOTAL_HI: rd_word = {16'h0000, total_hi_snap_q};
			`ADDR_OUT_SET: rd_word = {16'h0000, out_set_q};
			`ADDR_OUT_MIN: rd_word = {16'h0000, out_min_q};
			`ADDR_OUT_GAIN: rd_word = {16'h0000, out_gain_q};
			`ADDR_OUT_ZERO: rd_word = {16'h0000, out_zero_q};
			`ADDR_STATUS: rd_word = {30'h00000000, steps_seen_q, run_q};
			default: rd_hit = 1'b0;
		endcase
	end

	// reading the low word freezes the high word, so the pair is one sample
	always @* begin
		rvalid_d = s_axi_rvalid;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		total_hi_snap_d = total_hi_snap_q;
		if (do_read) begin
			rvalid_d = 1'b1;
			rdata_d = rd_word;
			rresp_d = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			if ({s_axi_araddr[7:2], 2'b00} == `ADDR_TOTAL_LO)
				total_hi_snap_d = total_q[31:16];
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
			total_hi_snap_q <= 16'h0000;
		end else begin
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
			total_hi_snap_q <= total_hi_snap_d;
		end
	end
endmodule

/* pvit_checker.sv */
// Purpose: bus and output trim timing checks on the integrator and trim block
// Assumes: one clock, synchronous active low reset
// Notes: integral total is not on the ports, the bench checks it over the bus
`timescale 1ns/100ps
`include "integrator_trim_consts.vh"
module pvit_checker #(
	parameter HOUR_STEP_CYCLES = 20,
	parameter MINUTE_STEP_CYCLES = 5
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] out_value,
	input wire out_valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ar = s_axi_arvalid && s_axi_arready;
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	chk_read_answer: assert property (ar |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (aw_w |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	chk_bad_read: assert property (ar && s_axi_araddr > 8'h2f |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_out_trim: assert property (aw_w && s_axi_awaddr == `ADDR_OUT_SET |-> ##[2:4] out_valid)
		else $error("output trim result missing");
	chk_out_pulse: assert property (out_valid |=> !out_valid)
		else $error("output strobe longer than one cycle");
	chk_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !out_valid)
		else $error("outputs busy after reset");
	cover property (aw_w && s_axi_awaddr == `ADDR_OUT_SET);
	cover property (ar && s_axi_araddr == `ADDR_TOTAL_HI);
	cover property (ar && s_axi_araddr > 8'h2f);
endmodule
bind process_value_integrator_and_trim pvit_checker #(.HOUR_STEP_CYCLES(HOUR_STEP_CYCLES),
	.MINUTE_STEP_CYCLES(MINUTE_STEP_CYCLES)) i_pvit_checker (.*);

/* ctrl_cpu_model.sv */
// Purpose: controller side bus master that writes settings and reads results
// Assumes: the slave answers in its own time, the bench watchdog ends a hang
// Notes: one write or one read at a time, each channel released when taken
`timescale 1ns/100ps
module ctrl_cpu_model (
	input wire aclk,
	output reg [7:0] s_axi_awaddr,
	output wire [2:0] s_axi_awprot,
	output reg s_axi_awvalid,
	input wire s_axi_awready,
	output reg [31:0] s_axi_wdata,
	output wire [3:0] s_axi_wstrb,
	output reg s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	output reg s_axi_bready,
	output reg [7:0] s_axi_araddr,
	output wire [2:0] s_axi_arprot,
	output reg s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	output reg s_axi_rready
);
	assign s_axi_awprot = 3'h0;
	assign s_axi_arprot = 3'h0;
	assign s_axi_wstrb = 4'hf;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
	end
	task wr(input [7:0] a, input [31:0] d);
		reg aw_done;
		reg w_done;
		begin
			aw_done = 1'b0;
			w_done = 1'b0;
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (!(aw_done && w_done)) begin
				@(posedge aclk);
				if (s_axi_awready)
					aw_done = 1'b1;
				if (s_axi_wready)
					w_done = 1'b1;
				if (aw_done)
					s_axi_awvalid <= 1'b0;
				if (w_done)
					s_axi_wvalid <= 1'b0;
			end
			while (!s_axi_bvalid)
				@(posedge aclk);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			@(posedge aclk);
			while (!s_axi_arready)
				@(posedge aclk);
			s_axi_arvalid <= 1'b0;
			@(posedge aclk);
			while (!s_axi_rvalid)
				@(posedge aclk);
			d = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
endmodule

/* test_process_value_integrator_and_trim.sv */
// Purpose: self-checking bench for the integrator and trim block
// Assumes: step counts shortened to 20 (hour) and 5 (minute) cycles
// Notes: run lengths sit mid-way between step edges so bus latency cannot shift the count
`timescale 1ns/100ps
`include "integrator_trim_consts.vh"
module test_process_value_integrator_and_trim;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [15:0] raw_value = 16'h0000;
	reg raw_valid = 1'b0;
	wire [7:0] s_axi_awaddr, s_axi_araddr;
	wire [2:0] s_axi_awprot, s_axi_arprot;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, out_valid;
	wire [15:0] out_value;
	integer failures = 0;
	integer n_compared = 0;
	integer b;
	integer i;
	reg [31:0] d;
	reg [1:0] r;
	always #5 aclk = ~aclk;
	process_value_integrator_and_trim #(.HOUR_STEP_CYCLES(20), .MINUTE_STEP_CYCLES(5))
		i_process_value_integrator_and_trim (.*);
	ctrl_cpu_model i_ctrl_cpu_model (.*);
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task put(input [7:0] a, input [15:0] v);
		i_ctrl_cpu_model.wr(a, {16'h0000, v});
	endtask
	task rdc(input [7:0] a, input [15:0] e);
		begin
			i_ctrl_cpu_model.rd(a, d, r);
			chk({16'h0000, d[15:0]}, {16'h0000, e});
		end
	endtask
	// pv is readable three edges after the strobe, four spare edges cover it
	task raw(input [15:0] v);
		begin
			@(posedge aclk);
			raw_value <= v;
			raw_valid <= 1'b1;
			@(posedge aclk);
			raw_valid <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask
	task tally_and_finish;
		begin
			$display("compared %0d mismatches %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial begin
		repeat (6000) @(posedge aclk);
		failures = failures + 1;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`ADDR_IN_GAIN, `RST_GAIN);
		rdc(`ADDR_IN_MIN, `RST_RANGE_MIN);
		i_ctrl_cpu_model.rd(8'h30, d, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		put(`ADDR_PV, 16'h1234);
		chk({30'h0, s_axi_bresp}, {30'h0, `RESP_SLVERR});
		rdc(`ADDR_PV, 16'h0000);
		$display("test reset done");
		put(`ADDR_IN_GAIN, 16'h274c);
		chk({30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
		put(`ADDR_IN_ZERO, 16'h0005);
		raw(16'h01f4);
		rdc(`ADDR_PV, 16'h01fc);
		put(`ADDR_IN_GAIN, 16'h1388);
		put(`ADDR_IN_ZERO, 16'h0000);
		raw(16'h0065);
		rdc(`ADDR_PV, 16'h0033);
		put(`ADDR_IN_GAIN, 16'h2710);
		raw(16'h8000);
		rdc(`ADDR_PV, 16'h8000);
		$display("test trim done");
		for (b = 0; b < 2; b = b + 1) begin
			put(`ADDR_CTRL, 16'h0004);
			rdc(`ADDR_TOTAL_LO, 16'h0000);
			put(`ADDR_CTRL, b[0] ? 16'h0003 : 16'h0001);
			repeat (b[0] ? 49 : 205) @(posedge aclk);
			put(`ADDR_CTRL, b[0] ? 16'h0002 : 16'h0000);
			rdc(`ADDR_TOTAL_LO, 16'hfeb8);
			rdc(`ADDR_TOTAL_HI, 16'hffff);
		end
		rdc(`ADDR_CTRL, 16'h0002);
		rdc(`ADDR_STATUS, 16'h0002);
		$display("test integrate done");
		put(`ADDR_OUT_MIN, 16'h0064);
		put(`ADDR_OUT_GAIN, 16'h274c);
		put(`ADDR_OUT_ZERO, 16'h0005);
		put(`ADDR_OUT_SET, 16'h01f4);
		i = 0;
		while (out_valid !== 1'b1 && i < 20) begin
			@(posedge aclk);
			i = i + 1;
		end
		chk({31'h0, out_valid}, 32'h00000001);
		chk({16'h0000, out_value}, 32'h000001fb);
		$display("test output trim done");
		tally_and_finish;
	end
endmodule
